// >>> core/blc_pkg.sv
package blc_pkg;

   // ------------------------------------------------------------
   // Register bus map (word index)
   // ------------------------------------------------------------
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_STATUS = 3'h1;
   localparam logic [2:0] REG_PC = 3'h2;
   localparam logic [2:0] REG_ACC = 3'h3;
   localparam logic [2:0] REG_PSW = 3'h4;
   localparam logic [2:0] REG_PORT = 3'h5;
   localparam logic [2:0] REG_PINS = 3'h6;

   localparam int CTRL_RUN = 0;
   localparam int STATUS_BUSY = 0;
   localparam int STATUS_ILLEGAL = 1;

   // ------------------------------------------------------------
   // Flag word layout
   // ------------------------------------------------------------
   localparam int PSW_CY = 7;
   localparam int PSW_AC = 6;
   localparam int PSW_RS_HI = 4;
   localparam int PSW_RS_LO = 3;
   localparam int PSW_OV = 2;

   // ------------------------------------------------------------
   // Internal address space
   // ------------------------------------------------------------
   localparam logic [7:0] SFR_BASE = 8'h80;
   localparam logic [7:0] SFR_PORT = 8'h90;
   localparam logic [7:0] SFR_PSW = 8'hD0;
   localparam logic [7:0] SFR_ACC = 8'hE0;
   localparam logic [7:0] BIT_RAM_BASE = 8'h20;
   localparam int RAM_WORDS = 128;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [15:0] RST_PC = 16'h0000;
   localparam logic [7:0] RST_ACC = 8'h00;
   localparam logic [7:0] RST_PSW = 8'h00;
   localparam logic [7:0] RST_PORT = 8'hFF;

   // ------------------------------------------------------------
   // Opcodes and fields
   // ------------------------------------------------------------
   localparam logic [3:0] HI_ADD_WITH_CARRY = 4'h3;
   localparam logic [3:0] HI_ANL = 4'h5;
   localparam logic [3:0] HI_COMPARE_JUMP_NOT_EQUAL = 4'hB;
   localparam logic [3:0] LO_IMM = 4'h4;
   localparam logic [3:0] LO_DIR = 4'h5;
   localparam logic [2:0] LO_IND = 3'h3;
   localparam logic [3:0] LO_DIR_A = 4'h2;
   localparam logic [3:0] LO_DIR_IMM = 4'h3;
   localparam logic [4:0] ABSOLUTE_PAGE_JUMP_LO = 5'h01;
   localparam logic [7:0] OP_ANL_C_BIT = 8'h82;
   localparam logic [7:0] OP_ANL_C_NBIT = 8'hB0;
   localparam logic [7:0] OP_CLR_A = 8'hE4;
   localparam logic [7:0] OP_CLR_C = 8'hC3;
   localparam logic [7:0] OP_CLR_BIT = 8'hC2;
   localparam logic [7:0] OP_CPL_A = 8'hF4;
   localparam logic [7:0] OP_CPL_C = 8'hB3;
   localparam logic [7:0] OP_CPL_BIT = 8'hB2;
   localparam logic [7:0] OP_DA = 8'hD4;
   localparam logic [7:0] OP_NOP = 8'h00;

   // ------------------------------------------------------------
   // Decimal adjust
   // ------------------------------------------------------------
   localparam logic [3:0] BCD_MAX = 4'h9;
   localparam logic [8:0] BCD_LO_FIX = 9'h006;
   localparam logic [8:0] BCD_HI_FIX = 9'h060;

   typedef enum logic [2:0] {
      BLC_IDLE,
      BLC_ADDR,
      BLC_WAIT,
      BLC_LOAD,
      BLC_EXEC
   } blc_state_type;

endpackage : blc_pkg

// >>> core/blc_add_adjust.sv
`timescale 1ns/1ns
module blc_add_adjust (
   // Operands
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic cin,
   input wire logic ac_in,
   input wire logic adjust,
   // Results
   output logic [7:0] res,
   output logic cy,
   output logic ac,
   output logic ov
);
   logic [4:0] low;
   logic [7:0] mid;
   logic [8:0] full;
   logic [8:0] fix;

   always_comb begin
      low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      mid = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      fix = {1'b0, a};
      if (adjust) begin
         // Adjust only ever sets carry, never clears it
         cy = cin;
         ac = ac_in;
         if (a[3:0] > blc_pkg::BCD_MAX || ac_in) begin
            fix = fix + blc_pkg::BCD_LO_FIX;
            cy = cy | fix[8];
         end
         if (fix[7:4] > blc_pkg::BCD_MAX || cy) begin
            fix = {1'b0, fix[7:0]} + blc_pkg::BCD_HI_FIX;
            cy = cy | fix[8];
         end
         res = fix[7:0];
         ov = 1'b0;
      end else begin
         res = full[7:0];
         cy = full[8];
         ac = low[4];
         ov = mid[7] ^ full[8];
      end
   end
endmodule : blc_add_adjust

// >>> core/blc_exec.sv
`timescale 1ns/1ns
// Operation
// - Add-with-carry sums accumulator, carry and source into accumulator in one cycle.
// - Absolute jump: two bytes, two cycles, replaces low 11 PC bits.
// - Byte AND stores bitwise AND in destination, flags untouched.
// - Read-modify-write on the output port reads the latch, not pins.
// - Byte AND opcodes 0x52-0x5F; direct-immediate form three bytes, two cycles.
// - Bit AND clears carry when source bit (or complement) is zero.
// - Bit AND into carry uses a direct bit address, two bytes, two cycles.
// - Compare-and-jump branches on inequality to next PC plus signed offset.
// - Compare-and-jump sets carry when destination is below source, else clears.
// - Compare-and-jump is three bytes, two cycles, opcodes 0xB4-0xBF.
// - Clear-accumulator zeroes all eight bits, no flag changes.
// - Clear-bit zeroes carry or any direct bit in one cycle.
// - Complement-accumulator inverts all bits in one cycle, no flags.
// - Complement-bit inverts carry or any direct bit in one cycle.
// - Decimal adjust turns a packed-BCD sum into two decimal digits.
// - Add-with-carry sets carry from bit 7, auxiliary carry from bit 3.
// - Overflow set when exactly one of bit 6 and bit 7 carries out.
// - Adjust adds six to low nibble above nine or on auxiliary carry.
// - Adjust adds six to high nibble on carry or above nine; overflow kept.
module blc_exec (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register bus
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Program memory
   output logic [15:0] pmem_addr,
   output logic pmem_rd,
   input wire logic [7:0] pmem_rdata,
   // Output port
   input wire logic [7:0] port_pins,
   output logic [7:0] port_out
);
   typedef struct packed {
      blc_pkg::blc_state_type st;
      logic [1:0] idx;
      logic cyc;
      logic [7:0] op;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [15:0] pc;
      logic [7:0] acc;
      logic [7:0] psw;
      logic [7:0] port;
      logic [7:0] pins_m;
      logic [7:0] pins_s;
      logic [blc_pkg::RAM_WORDS-1:0][7:0] ram;
      logic run;
      logic illegal;
      logic [15:0] pmem_addr;
      logic pmem_rd;
      logic av_wait;
      logic [31:0] av_rdata;
   } blc_regs_type;
   blc_regs_type q;
   blc_regs_type d;
   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   // Length zero marks an opcode this unit does not execute
   function automatic logic [1:0] op_len(input logic [7:0] op);
      logic [1:0] n;
      n = 2'd0;
      if (op[4:0] == blc_pkg::ABSOLUTE_PAGE_JUMP_LO) begin
         n = 2'd2;
      end else if (op[7:4] == blc_pkg::HI_ADD_WITH_CARRY || op[7:4] == blc_pkg::HI_ANL) begin
         if (op[3] || op[3:1] == blc_pkg::LO_IND) begin
            n = 2'd1;
         end else if (op[3:0] == blc_pkg::LO_IMM || op[3:0] == blc_pkg::LO_DIR) begin
            n = 2'd2;
         end else if (op[7:4] == blc_pkg::HI_ANL && op[3:0] == blc_pkg::LO_DIR_A) begin
            n = 2'd2;
         end else if (op[7:4] == blc_pkg::HI_ANL && op[3:0] == blc_pkg::LO_DIR_IMM) begin
            n = 2'd3;
         end
      end else if (op[7:4] == blc_pkg::HI_COMPARE_JUMP_NOT_EQUAL && op[3:0] >= blc_pkg::LO_IMM) begin
         n = 2'd3;
      end else if (op == blc_pkg::OP_ANL_C_BIT || op == blc_pkg::OP_ANL_C_NBIT
                   || op == blc_pkg::OP_CLR_BIT || op == blc_pkg::OP_CPL_BIT) begin
         n = 2'd2;
      end else if (op == blc_pkg::OP_CLR_A || op == blc_pkg::OP_CLR_C
                   || op == blc_pkg::OP_CPL_A || op == blc_pkg::OP_CPL_C
                   || op == blc_pkg::OP_DA || op == blc_pkg::OP_NOP) begin
         n = 2'd1;
      end
      return n;
   endfunction : op_len
   function automatic logic two_cycle(input logic [7:0] op);
      return op[4:0] == blc_pkg::ABSOLUTE_PAGE_JUMP_LO
         || op == {blc_pkg::HI_ANL, blc_pkg::LO_DIR_IMM}
         || op == blc_pkg::OP_ANL_C_BIT || op == blc_pkg::OP_ANL_C_NBIT
         || (op[7:4] == blc_pkg::HI_COMPARE_JUMP_NOT_EQUAL && op[3:0] >= blc_pkg::LO_IMM);
   endfunction : two_cycle
   // Port reads see pins normally, the latch inside read-modify-write
   function automatic logic [7:0] rd_dir(input blc_regs_type s, input logic [7:0] a,
                                         input logic rmw);
      logic [7:0] v;
      v = 8'h00;
      if (a < blc_pkg::SFR_BASE) begin
         v = s.ram[a[6:0]];
      end else if (a == blc_pkg::SFR_ACC) begin
         v = s.acc;
      end else if (a == blc_pkg::SFR_PSW) begin
         v = s.psw;
      end else if (a == blc_pkg::SFR_PORT) begin
         v = rmw ? s.port : s.pins_s;
      end
      return v;
   endfunction : rd_dir
   function automatic logic [7:0] bit_byte(input logic [7:0] b);
      return (b < blc_pkg::SFR_BASE) ? blc_pkg::BIT_RAM_BASE + {4'h0, b[6:3]} : {b[7:3], 3'h0};
   endfunction : bit_byte
   // ------------------------------------------------------------
   // Datapath
   // ------------------------------------------------------------
   logic [7:0] wreg;
   logic [7:0] ptr;
   logic [7:0] ind;
   logic [7:0] src;
   logic [7:0] dst;
   logic [7:0] bbyte;
   logic [7:0] bmask;
   logic [7:0] sum;
   logic sum_cy;
   logic sum_ac;
   logic sum_ov;
   logic [1:0] len;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_val;
   always_comb begin
      wreg = q.ram[{2'h0, q.psw[blc_pkg::PSW_RS_HI:blc_pkg::PSW_RS_LO], q.op[2:0]}];
      ptr = q.ram[{2'h0, q.psw[blc_pkg::PSW_RS_HI:blc_pkg::PSW_RS_LO], 2'h0, q.op[0]}];
      ind = q.ram[ptr[6:0]];
      // Register and indirect compares take the immediate byte as source
      if (q.op[7:4] == blc_pkg::HI_COMPARE_JUMP_NOT_EQUAL && q.op[3:0] != blc_pkg::LO_DIR) begin
         src = q.b1;
      end else if (q.op[3]) begin
         src = wreg;
      end else if (q.op[3:1] == blc_pkg::LO_IND) begin
         src = ind;
      end else if (q.op[3:0] == blc_pkg::LO_DIR) begin
         src = rd_dir(q, q.b1, 1'b0);
      end else begin
         src = q.b1;
      end
      bbyte = bit_byte(q.b1);
      bmask = 8'h01 << q.b1[2:0];
   end
   blc_add_adjust u_alu (
      .a(q.acc),
      .b(src),
      .cin(q.psw[blc_pkg::PSW_CY]),
      .ac_in(q.psw[blc_pkg::PSW_AC]),
      .adjust(q.op == blc_pkg::OP_DA),
      .res(sum),
      .cy(sum_cy),
      .ac(sum_ac),
      .ov(sum_ov)
   );
   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      d = q;
      dst = q.acc;
      wr_en = 1'b0;
      wr_addr = 8'h00;
      wr_val = 8'h00;
      len = op_len(q.op);
      d.pins_m = port_pins;
      d.pins_s = q.pins_m;
      d.pmem_rd = 1'b0;
      // Bus slave: one wait cycle, then answer; software writes land first
      d.av_wait = 1'b1;
      if ((avs_read || avs_write) && q.av_wait) begin
         d.av_wait = 1'b0;
         unique case (avs_address)
            blc_pkg::REG_CTRL: d.av_rdata = {31'h0, q.run};
            blc_pkg::REG_STATUS: d.av_rdata = {30'h0, q.illegal, q.st != blc_pkg::BLC_IDLE};
            blc_pkg::REG_PC: d.av_rdata = {16'h0, q.pc};
            blc_pkg::REG_ACC: d.av_rdata = {24'h0, q.acc};
            blc_pkg::REG_PSW: d.av_rdata = {24'h0, q.psw};
            blc_pkg::REG_PORT: d.av_rdata = {24'h0, q.port};
            blc_pkg::REG_PINS: d.av_rdata = {24'h0, q.pins_s};
            default: d.av_rdata = 32'h0;
         endcase
      end
      if (avs_write && !q.av_wait) begin
         unique case (avs_address)
            blc_pkg::REG_CTRL: d.run = avs_writedata[blc_pkg::CTRL_RUN];
            blc_pkg::REG_STATUS: begin
               if (avs_writedata[blc_pkg::STATUS_ILLEGAL]) begin
                  d.illegal = 1'b0;
               end
            end
            blc_pkg::REG_PC: d.pc = avs_writedata[15:0];
            blc_pkg::REG_ACC: d.acc = avs_writedata[7:0];
            blc_pkg::REG_PSW: d.psw = avs_writedata[7:0];
            blc_pkg::REG_PORT: d.port = avs_writedata[7:0];
            default: d.run = d.run;
         endcase
      end
      unique case (q.st)
         blc_pkg::BLC_IDLE: begin
            d.idx = 2'd0;
            if (q.run) begin
               d.st = blc_pkg::BLC_ADDR;
            end
         end
         blc_pkg::BLC_ADDR: begin
            d.pmem_addr = q.pc + {14'h0, q.idx};
            d.pmem_rd = 1'b1;
            d.st = blc_pkg::BLC_WAIT;
         end
         blc_pkg::BLC_WAIT: d.st = blc_pkg::BLC_LOAD;
         blc_pkg::BLC_LOAD: begin
            if (q.idx == 2'd0) begin
               d.op = pmem_rdata;
               len = op_len(pmem_rdata);
            end else if (q.idx == 2'd1) begin
               d.b1 = pmem_rdata;
            end else begin
               d.b2 = pmem_rdata;
            end
            // Unknown opcodes stop the core; software restarts it
            if (len == 2'd0) begin
               d.illegal = 1'b1;
               d.run = 1'b0;
               d.st = blc_pkg::BLC_IDLE;
            end else if (q.idx + 2'd1 < len) begin
               d.idx = q.idx + 2'd1;
               d.st = blc_pkg::BLC_ADDR;
            end else begin
               d.pc = q.pc + {14'h0, len};
               d.cyc = two_cycle(d.op);
               d.st = blc_pkg::BLC_EXEC;
            end
         end
         blc_pkg::BLC_EXEC: begin
            // Two-cycle forms spend the first cycle here idle
            if (q.cyc) begin
               d.cyc = 1'b0;
            end else begin
               d.idx = 2'd0;
               d.st = q.run ? blc_pkg::BLC_ADDR : blc_pkg::BLC_IDLE;
               if (q.op[4:0] == blc_pkg::ABSOLUTE_PAGE_JUMP_LO) begin
                  d.pc = {q.pc[15:11], q.op[7:5], q.b1};
               end else if (q.op[7:4] == blc_pkg::HI_ADD_WITH_CARRY || q.op == blc_pkg::OP_DA) begin
                  d.acc = sum;
                  d.psw[blc_pkg::PSW_CY] = sum_cy;
                  d.psw[blc_pkg::PSW_AC] = sum_ac;
                  if (q.op != blc_pkg::OP_DA) begin
                     d.psw[blc_pkg::PSW_OV] = sum_ov;
                  end
               end else if (q.op[7:4] == blc_pkg::HI_ANL) begin
                  if (q.op[3:0] == blc_pkg::LO_DIR_A) begin
                     wr_en = 1'b1;
                     wr_addr = q.b1;
                     wr_val = rd_dir(q, q.b1, 1'b1) & q.acc;
                  end else if (q.op[3:0] == blc_pkg::LO_DIR_IMM) begin
                     wr_en = 1'b1;
                     wr_addr = q.b1;
                     wr_val = rd_dir(q, q.b1, 1'b1) & q.b2;
                  end else begin
                     d.acc = q.acc & src;
                  end
               end else if (q.op[7:4] == blc_pkg::HI_COMPARE_JUMP_NOT_EQUAL && q.op[3:0] >= blc_pkg::LO_IMM) begin
                  if (q.op[3]) begin
                     dst = wreg;
                  end else if (q.op[3:1] == blc_pkg::LO_IND) begin
                     dst = ind;
                  end
                  d.psw[blc_pkg::PSW_CY] = dst < src;
                  if (dst != src) begin
                     d.pc = q.pc + {{8{q.b2[7]}}, q.b2};
                  end
               end else if (q.op == blc_pkg::OP_ANL_C_BIT || q.op == blc_pkg::OP_ANL_C_NBIT) begin
                  if (((rd_dir(q, bbyte, 1'b0) & bmask) != 8'h00) == q.op[5]) begin
                     d.psw[blc_pkg::PSW_CY] = 1'b0;
                  end
               end else if (q.op == blc_pkg::OP_CLR_A) begin
                  d.acc = 8'h00;
               end else if (q.op == blc_pkg::OP_CPL_A) begin
                  d.acc = ~q.acc;
               end else if (q.op == blc_pkg::OP_CLR_C) begin
                  d.psw[blc_pkg::PSW_CY] = 1'b0;
               end else if (q.op == blc_pkg::OP_CPL_C) begin
                  d.psw[blc_pkg::PSW_CY] = ~q.psw[blc_pkg::PSW_CY];
               end else if (q.op == blc_pkg::OP_CLR_BIT || q.op == blc_pkg::OP_CPL_BIT) begin
                  wr_en = 1'b1;
                  wr_addr = bbyte;
                  wr_val = (q.op == blc_pkg::OP_CLR_BIT) ? rd_dir(q, bbyte, 1'b1) & ~bmask
                                                         : rd_dir(q, bbyte, 1'b1) ^ bmask;
               end
            end
         end
         default: d.st = blc_pkg::BLC_IDLE;
      endcase
      if (wr_en) begin
         if (wr_addr < blc_pkg::SFR_BASE) begin
            d.ram[wr_addr[6:0]] = wr_val;
         end else if (wr_addr == blc_pkg::SFR_ACC) begin
            d.acc = wr_val;
         end else if (wr_addr == blc_pkg::SFR_PSW) begin
            d.psw = wr_val;
         end else if (wr_addr == blc_pkg::SFR_PORT) begin
            d.port = wr_val;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.st <= blc_pkg::BLC_IDLE;
         q.pc <= blc_pkg::RST_PC;
         q.acc <= blc_pkg::RST_ACC;
         q.psw <= blc_pkg::RST_PSW;
         q.port <= blc_pkg::RST_PORT;
         q.av_wait <= 1'b1;
      end else begin
         q <= d;
      end
   end
   assign avs_readdata = q.av_rdata;
   assign avs_waitrequest = q.av_wait;
   assign pmem_addr = q.pmem_addr;
   assign pmem_rd = q.pmem_rd;
   assign port_out = q.port;
endmodule : blc_exec

// >>> sim/blc_exec_properties.sv
`timescale 1ns/1ns
module blc_exec_properties (
   // Bus side
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Fetch and port side
   input wire logic [15:0] pmem_addr,
   input wire logic pmem_rd,
   input wire logic [7:0] pmem_rdata,
   input wire logic [7:0] port_pins,
   input wire logic [7:0] port_out
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ------------------------------------------------------------
   // Register bus
   // ------------------------------------------------------------
   chk_wait_answer: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait low too long");
   chk_unmapped_zero: assert property (
      avs_read && !avs_waitrequest && avs_address == 3'h7 |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   chk_port_write: assert property (
      avs_write && !avs_waitrequest && avs_address == blc_pkg::REG_PORT
      |=> port_out == $past(avs_writedata[7:0]))
      else $error("port latch write lost");
   // ------------------------------------------------------------
   // Fetch timing; opcodes are known one cycle after the strobe
   // ------------------------------------------------------------
   chk_fetch_spacing: assert property (pmem_rd |=> !pmem_rd [*2])
      else $error("fetch strobes too close");
   chk_fetch_ascend: assert property (
      pmem_rd ##3 pmem_rd |-> pmem_addr == $past(pmem_addr, 3) + 16'h0001)
      else $error("instruction bytes not ascending");
   chk_single_exec: assert property (
      pmem_rd ##1 (pmem_rdata inside {8'hE4, 8'hF4, 8'hC3, 8'hB3}) |-> ##3 pmem_rd)
      else $error("one byte op not single cycle");
   chk_add_with_carry_exec: assert property (
      pmem_rd ##1 (pmem_rdata[7:3] == 5'h07 || pmem_rdata[7:1] == 7'h1B) |-> ##3 pmem_rd)
      else $error("add with carry not single cycle");
   chk_three_byte: assert property (
      pmem_rd ##1 ((pmem_rdata[7:4] == 4'hB && pmem_rdata[3:2] != 2'h0)
      || pmem_rdata == 8'h53) |-> ##2 pmem_rd ##3 pmem_rd ##5 pmem_rd)
      else $error("three byte op timing wrong");
   chk_bit_and: assert property (
      pmem_rd ##1 (pmem_rdata == 8'h82 || pmem_rdata == 8'hB0) |-> ##2 pmem_rd ##5 pmem_rd)
      else $error("bit and timing wrong");
   chk_page_jump: assert property (
      pmem_rd ##1 pmem_rdata[4:0] == 5'h01 |-> ##2 pmem_rd ##5 pmem_rd)
      else $error("page jump timing wrong");
   cover property (pmem_rd ##1 pmem_rdata == 8'hB5);
   cover property (pmem_rd ##1 pmem_rdata[4:0] == 5'h01);
   cover property (avs_read && !avs_waitrequest && avs_address == 3'h7);
   cover property (avs_write && !avs_waitrequest && avs_address == blc_pkg::REG_PORT);
endmodule : blc_exec_properties

// >>> sim/blc_pmem_model.sv
`timescale 1ns/1ns
module blc_pmem_model (
   // Fetch port
   input wire logic clk,
   input wire logic [15:0] pmem_addr,
   input wire logic pmem_rd,
   output logic [7:0] pmem_rdata
);
   logic [7:0] mem [0:65535];
   // Unused bytes halt the core, so a stray fetch ends the run
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'hA5;
      end
      pmem_rdata = 8'h00;
   end
   // Latency is fixed by the core; outside the valid cycle the byte toggles
   always @(posedge clk) begin
      if (pmem_rd) begin
         pmem_rdata <= mem[pmem_addr];
      end else begin
         pmem_rdata <= ~pmem_rdata;
      end
   end
endmodule : blc_pmem_model

// >>> sim/blc_exec_tb_top.sv
`timescale 1ns/1ns
module blc_exec_tb_top;
   logic clk;
   logic rst_n;
   logic [2:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [15:0] pmem_addr;
   logic pmem_rd;
   logic [7:0] pmem_rdata;
   logic [7:0] port_pins;
   logic [7:0] port_out;
   logic [31:0] rsp;
   int fails = 0;
   int check_count = 0;
   int cycles = 0;

   blc_exec DUT (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
      .pmem_rdata(pmem_rdata), .port_pins(port_pins), .port_out(port_out));
   blc_pmem_model u_mem (.clk(clk), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
      .pmem_rdata(pmem_rdata));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task print_verdict;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict

   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         fails++;
         print_verdict;
      end
   end

   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // ------------------------------------------------------------
   // Bus access: held until wait is seen low at an edge
   // ------------------------------------------------------------
   task bus(input logic w, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      // Slave answers after exactly one wait state
      chk("bus wait", n, 32'h2);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask : bus

   task reg_wr(input logic [2:0] a, input logic [31:0] d);
      bus(1'b1, a, d, rsp);
   endtask : reg_wr

   task reg_rd(input logic [2:0] a, input logic [31:0] exp, input string name);
      bus(1'b0, a, 32'h0, rsp);
      chk(name, rsp, exp);
   endtask : reg_rd

   // Row: start pc, three bytes, acc and flags before, after, halt pc
   task step(input logic [87:0] r);
      u_mem.mem[r[87:72]] = r[71:64];
      u_mem.mem[r[87:72] + 16'h1] = r[63:56];
      u_mem.mem[r[87:72] + 16'h2] = r[55:48];
      u_mem.mem[r[15:0]] = 8'hA5;
      reg_wr(blc_pkg::REG_PC, {16'h0, r[87:72]});
      reg_wr(blc_pkg::REG_ACC, {24'h0, r[47:40]});
      reg_wr(blc_pkg::REG_PSW, {24'h0, r[39:32]});
      reg_wr(blc_pkg::REG_CTRL, 32'h1);
      do begin
         bus(1'b0, blc_pkg::REG_STATUS, 32'h0, rsp);
      end while (rsp[0] !== 1'b0);
      chk("status", rsp, 32'h2);
      reg_wr(blc_pkg::REG_STATUS, 32'h2);
      reg_rd(blc_pkg::REG_ACC, {24'h0, r[31:24]}, "acc");
      reg_rd(blc_pkg::REG_PSW, {24'h0, r[23:16]}, "psw");
      reg_rd(blc_pkg::REG_PC, {16'h0, r[15:0]}, "pc");
   endtask : step

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_reset;
      reg_rd(blc_pkg::REG_CTRL, 32'h0, "ctrl");
      reg_rd(blc_pkg::REG_STATUS, 32'h0, "status");
      reg_rd(blc_pkg::REG_PC, 32'h0, "pc");
      reg_rd(blc_pkg::REG_ACC, 32'h0, "acc");
      reg_rd(blc_pkg::REG_PSW, 32'h0, "psw");
      reg_rd(blc_pkg::REG_PORT, 32'hFF, "port");
      reg_wr(3'h7, 32'hFF);
      reg_rd(3'h7, 32'h0, "unmapped");
      reg_rd(blc_pkg::REG_PINS, 32'h3C, "pins");
      $display("t_reset done");
   endtask : t_reset

   task t_add_with_carry;
      step(88'h0040_34AA00_C380_6E84_0042);
      step(88'h0040_380000_6E80_6F00_0041);
      step(88'h0040_360000_FF80_00C0_0041);
      step(88'h0040_35E000_6F00_DE44_0042);
      step(88'h0040_3467D4_5680_2484_0043);
      step(88'h0040_3499D4_3000_2980_0043);
      step(88'h0040_3409D4_0900_1840_0043);
      $display("t_add_with_carry done");
   endtask : t_add_with_carry

   task t_logic;
      step(88'h0040_545500_C3C4_41C4_0042);
      step(88'h0040_580000_C3C4_00C4_0041);
      step(88'h0040_560000_C3C4_00C4_0041);
      step(88'h0040_55D000_FFC4_C4C4_0042);
      step(88'h0040_82E700_80C4_80C4_0042);
      step(88'h0040_82E700_00C4_0044_0042);
      step(88'h0040_B0E700_80C4_8044_0042);
      step(88'h0040_B0E700_00C4_00C4_0042);
      step(88'h0040_E40000_5CC4_00C4_0041);
      step(88'h0040_F40000_5CC4_A3C4_0041);
      step(88'h0040_C30000_5CC4_5C44_0041);
      step(88'h0040_C2E700_80C4_00C4_0042);
      step(88'h0040_B30000_0044_00C4_0041);
      step(88'h0040_B2E000_0004_0104_0042);
      $display("t_logic done");
   endtask : t_logic

   task t_branch;
      step(88'h0040_B46010_3400_3480_0053);
      step(88'h0040_B43410_3480_3400_0043);
      step(88'h0040_B400F0_3480_3400_0033);
      step(88'h0040_B5D005_0304_0384_0048);
      step(88'h0040_B80202_0000_0080_0045);
      step(88'h0040_B60002_0080_0000_0043);
      step(88'h0345_212300_0000_0000_0123);
      step(88'h07FE_E11000_0000_0000_0F10);
      $display("t_branch done");
   endtask : t_branch

   // Pins differ from the latch, so a pin read shows up at once
   task t_port;
      reg_wr(blc_pkg::REG_PORT, 32'h5D);
      step(88'h0040_539073_0000_0000_0043);
      chk("port", {24'h0, port_out}, 32'h51);
      step(88'h0040_529000_4100_4100_0042);
      chk("port", {24'h0, port_out}, 32'h41);
      step(88'h0040_B29100_0000_0000_0042);
      chk("port", {24'h0, port_out}, 32'h43);
      step(88'h0040_C29600_0000_0000_0042);
      reg_rd(blc_pkg::REG_PORT, 32'h03, "port");
      step(88'h0040_559000_FF00_3C00_0042);
      $display("t_port done");
   endtask : t_port

   initial begin
      rst_n = 1'b0;
      avs_address = 3'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      port_pins = 8'h3C;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset;
      t_add_with_carry;
      t_logic;
      t_branch;
      t_port;
      print_verdict;
   end
endmodule : blc_exec_tb_top

bind blc_exec blc_exec_properties u_props (.clk(clk), .rst_n(rst_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
   .pmem_rdata(pmem_rdata), .port_pins(port_pins), .port_out(port_out));
